// ==== rtl/mct_pkg.sv ====
/*
  Constants for the multi-channel capture/compare timer: register byte
  offsets, field positions, mode codes and reset values.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package multichannel_counter_pkg;
  // Channel count and counter width
  localparam int NCH = 4;
  localparam int CW = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] COUNT_OFF = 8'h04;
  localparam logic [7:0] RELOAD_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [3:0] CHCTL_REGION = 4'h1;
  localparam logic [3:0] CMP_REGION = 4'h2;

  // Timer control fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_CIE_BIT = 3;

  // Channel control fields
  localparam int CH_EN_BIT = 0;
  localparam int CH_MODE_LSB = 1;
  localparam int CH_POL_BIT = 3;
  localparam int CH_IE_BIT = 4;
  localparam int CH_UPD_BIT = 5;

  // Status fields: channel flags in low bits
  localparam int ST_CNT_BIT = 4;

  // Counting modes
  localparam logic [1:0] MODE_MODULO = 2'b00;
  localparam logic [1:0] MODE_UPDOWN = 2'b10;

  // Channel modes
  localparam logic [1:0] CH_ONESHOT = 2'b00;
  localparam logic [1:0] CH_CONT = 2'b01;
  localparam logic [1:0] CH_PWM = 2'b10;
  localparam logic [1:0] CH_CAPT = 2'b11;

  // Reset values
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
endpackage

// ==== rtl/multichannel_counter.sv ====
/*
  Multi-channel timer: 16-bit modulo or up/down counter shared by four
  capture/compare/PWM channels, with APB registers, one combined
  interrupt and per-channel DMA requests.
  Assumes channel inputs and DMA acknowledges are synchronous to pclk.
*/
// Local design decisions: the placing of the registers and the APB slave port.
// Overview of operation
// (RULE1) Modulo: count to reload, wrap to zero
// (RULE2) Modulo above reload restarts from zero
// (RULE3) Up/down: up to reload, down to zero
// (RULE4) Count-cycle end raises counter interrupt
// (RULE5) Four channels share counter, four modes
// (RULE6) Compare writes wait for cycle end
// (RULE7) Immediate-update bit makes writes direct
// (RULE8) One-shot match flags, interrupts, disables channel
// (RULE9) One-shot output pulses one clock
// (RULE10) Continuous match flags, pulses, stays enabled
// (RULE11) Software sets polarity before enable
// (RULE12) PWM starts at polarity, inverts on match
// (RULE13) PWM modulo restores level at wrap
// (RULE14) PWM up/down restores on down match
// (RULE15) Capture copies count, flags, interrupts
// (RULE16) Polarity picks capture edge
// (RULE17) Channel interrupt needs its enable bit
// (RULE18) All sources share one interrupt
// (RULE19) Non-capture channel events raise DMA request; code requires the channel IE bit, and one-shot events raise none
// (RULE20) Software avoids DMA in one-shot
// (RULE21) Runs in halt, freezes with clock
// (RULE22) Enables gate logic, registers stay accessible
// (RULE23) Mode codes 00 modulo, 10 up/down
// (RULE24) Counting starts when counter enabled
// (RULE25) Event flags stay until software clears
`timescale 1ns/1ps
module multichannel_counter import multichannel_counter_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel pins
  input wire logic [NCH-1:0] ch_in,
  output logic [NCH-1:0] ch_out,
  // Interrupt and DMA
  output logic irq,
  output logic [NCH-1:0] dma_req,
  input wire logic [NCH-1:0] dma_ack
);

  typedef struct packed {
    logic tmr_en;
    logic [1:0] cmode;
    logic cnt_ie;
    logic [CW-1:0] cnt;
    logic cnt_down;
    logic [CW-1:0] reload;
    logic [NCH-1:0] ch_en;
    logic [NCH-1:0][1:0] ch_mode;
    logic [NCH-1:0] ch_pol;
    logic [NCH-1:0] ch_ie;
    logic [NCH-1:0] ch_upd;
    logic [NCH-1:0][CW-1:0] cmp;
    logic [NCH-1:0][CW-1:0] cmp_buf;
    logic [NCH-1:0] buf_pend;
    logic [NCH-1:0] ev_flag;
    logic cnt_flag;
    logic [NCH-1:0] in_prev;
    logic [NCH-1:0] out;
    logic [NCH-1:0] dma;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_r, s_nxt;
  logic tick, eoc, wr, setup, wr_cnt;
  logic [NCH-1:0] ev;
  logic [1:0] ci;

  // Decodes a mapped register address
  function automatic logic reg_hit(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'b00) && ((a[7:4] == CHCTL_REGION) || (a[7:4] == CMP_REGION) ||
         (a == CTRL_OFF) || (a == COUNT_OFF) || (a == RELOAD_OFF) || (a == STATUS_OFF));
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    tick = s_r.tmr_en; // see (RULE24) (RULE22)
    eoc = 1'b0;
    ev = '0;
    ci = paddr[3:2];
    setup = psel & ~penable;
    wr = psel & penable & s_r.pready & pwrite & reg_hit(paddr);
    wr_cnt = wr && (paddr == COUNT_OFF);

    // Counter stepping
    if (tick) begin
      unique case (s_r.cmode) // see (RULE23)
        MODE_MODULO: begin
          s_nxt.cnt_down = 1'b0;
          if (s_r.cnt >= s_r.reload) begin // see (RULE1) (RULE2)
            s_nxt.cnt = COUNT_RST;
            eoc = (s_r.cnt == s_r.reload);
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
        MODE_UPDOWN: begin
          if (!s_r.cnt_down) begin // see (RULE3)
            if (s_r.cnt >= s_r.reload) begin
              if (s_r.cnt != 16'h0000) begin
                s_nxt.cnt_down = 1'b1;
                s_nxt.cnt = s_r.cnt - 16'h0001;
              end
            end else begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end else if (s_r.cnt <= 16'h0001) begin
            s_nxt.cnt = COUNT_RST;
            s_nxt.cnt_down = 1'b0;
            eoc = (s_r.cnt == 16'h0001);
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end
        end
        default: begin
          s_nxt.cnt = s_r.cnt; // Reserved codes hold the count
        end
      endcase
    end

    // Count-cycle end: flag and buffered compare load
    if (eoc) begin
      s_nxt.cnt_flag = 1'b1; // see (RULE4)
    end
    for (int i = 0; i < NCH; i++) begin
      if (eoc && s_r.buf_pend[i]) begin
        s_nxt.cmp[i] = s_r.cmp_buf[i]; // see (RULE6)
        s_nxt.buf_pend[i] = 1'b0;
      end
    end

    // Register writes, taken at the access edge
    if (wr) begin // see (RULE22)
      if (paddr == CTRL_OFF) begin
        s_nxt.tmr_en = pwdata[CTL_EN_BIT];
        s_nxt.cmode = pwdata[CTL_MODE_LSB +: 2];
        s_nxt.cnt_ie = pwdata[CTL_CIE_BIT];
      end else if (paddr == COUNT_OFF) begin
        s_nxt.cnt = pwdata[CW-1:0];
      end else if (paddr == RELOAD_OFF) begin
        s_nxt.reload = pwdata[CW-1:0];
      end else if (paddr == STATUS_OFF) begin
        s_nxt.ev_flag = s_nxt.ev_flag & ~pwdata[NCH-1:0]; // see (RULE25)
        s_nxt.cnt_flag = (s_r.cnt_flag & ~pwdata[ST_CNT_BIT]) | eoc; // Set wins
      end else if (paddr[7:4] == CHCTL_REGION) begin
        s_nxt.ch_en[ci] = pwdata[CH_EN_BIT];
        s_nxt.ch_mode[ci] = pwdata[CH_MODE_LSB +: 2];
        s_nxt.ch_pol[ci] = pwdata[CH_POL_BIT];
        s_nxt.ch_ie[ci] = pwdata[CH_IE_BIT];
        s_nxt.ch_upd[ci] = pwdata[CH_UPD_BIT];
      end else if (s_r.tmr_en && !s_r.ch_upd[ci]) begin
        s_nxt.cmp_buf[ci] = pwdata[CW-1:0]; // see (RULE6)
        s_nxt.buf_pend[ci] = 1'b1;
      end else begin
        s_nxt.cmp[ci] = pwdata[CW-1:0]; // see (RULE7)
        s_nxt.buf_pend[ci] = 1'b0;
      end
    end

    // Channel logic, gated by both enables
    for (int i = 0; i < NCH; i++) begin // see (RULE5)
      s_nxt.in_prev[i] = ch_in[i];
      if (tick && s_r.ch_en[i]) begin
        if (s_r.ch_mode[i] == CH_CAPT) begin
          // Polarity 1 selects rising, 0 falling
          if (ch_in[i] != s_r.in_prev[i] && ch_in[i] == s_r.ch_pol[i]) begin // see (RULE16)
            ev[i] = 1'b1;
            s_nxt.cmp[i] = s_r.cnt; // see (RULE15)
          end
        end else begin
          ev[i] = (s_r.cnt == s_r.cmp[i]);
        end
      end
      if (ev[i]) begin
        s_nxt.ev_flag[i] = 1'b1; // see (RULE8) (RULE10) (RULE12) (RULE15)
      end
      if (ev[i] && s_r.ch_mode[i] == CH_ONESHOT) begin
        s_nxt.ch_en[i] = 1'b0; // see (RULE8)
      end
      // Output level
      if (!s_r.ch_en[i]) begin
        s_nxt.out[i] = s_r.ch_pol[i];
      end else if (!tick) begin
        s_nxt.out[i] = (s_r.ch_mode[i] == CH_PWM) ? s_r.out[i] : s_r.ch_pol[i];
      end else begin
        unique case (s_r.ch_mode[i])
          CH_ONESHOT, CH_CONT: s_nxt.out[i] = s_r.ch_pol[i] ^ ev[i]; // see (RULE9) (RULE10)
          CH_PWM: begin
            if (s_r.cmode == MODE_MODULO && s_r.cnt >= s_r.reload) begin
              s_nxt.out[i] = s_r.ch_pol[i]; // see (RULE13)
            end else if (ev[i] && s_r.cnt_down) begin
              s_nxt.out[i] = s_r.ch_pol[i]; // see (RULE14)
            end else if (ev[i]) begin
              s_nxt.out[i] = ~s_r.ch_pol[i]; // see (RULE12)
            end
          end
          CH_CAPT: s_nxt.out[i] = s_r.ch_pol[i];
        endcase
      end
      // DMA request: set on non-capture event with the channel interrupt enable set, cleared by ack or disable
      if (ev[i] && s_r.ch_ie[i] && s_r.ch_mode[i] != CH_CAPT) begin
        s_nxt.dma[i] = 1'b1; // see (RULE19)
      end else if (dma_ack[i]) begin
        s_nxt.dma[i] = 1'b0;
      end
      if (!s_nxt.ch_en[i]) begin
        s_nxt.dma[i] = 1'b0; // see (RULE19) (RULE20)
      end
    end

    // Combined interrupt from sticky flags
    s_nxt.irq = (|(s_nxt.ev_flag & s_nxt.ch_ie)) | (s_nxt.cnt_flag & s_nxt.cnt_ie); // see (RULE17) (RULE18)

    // Read data and ready, prepared in the setup cycle
    s_nxt.pready = setup;
    s_nxt.pslverr = setup & ~reg_hit(paddr);
    if (setup) begin
      s_nxt.prdata = 32'h0000_0000;
      if (paddr == CTRL_OFF) begin
        s_nxt.prdata[CTL_EN_BIT] = s_r.tmr_en;
        s_nxt.prdata[CTL_MODE_LSB +: 2] = s_r.cmode;
        s_nxt.prdata[CTL_CIE_BIT] = s_r.cnt_ie;
      end else if (paddr == COUNT_OFF) begin
        s_nxt.prdata[CW-1:0] = s_r.cnt;
      end else if (paddr == RELOAD_OFF) begin
        s_nxt.prdata[CW-1:0] = s_r.reload;
      end else if (paddr == STATUS_OFF) begin
        s_nxt.prdata[NCH-1:0] = s_r.ev_flag;
        s_nxt.prdata[ST_CNT_BIT] = s_r.cnt_flag;
      end else if (paddr[1:0] == 2'b00 && paddr[7:4] == CHCTL_REGION) begin
        s_nxt.prdata[CH_EN_BIT] = s_r.ch_en[ci];
        s_nxt.prdata[CH_MODE_LSB +: 2] = s_r.ch_mode[ci];
        s_nxt.prdata[CH_POL_BIT] = s_r.ch_pol[ci];
        s_nxt.prdata[CH_IE_BIT] = s_r.ch_ie[ci];
        s_nxt.prdata[CH_UPD_BIT] = s_r.ch_upd[ci];
      end else if (paddr[1:0] == 2'b00 && paddr[7:4] == CMP_REGION) begin
        s_nxt.prdata[CW-1:0] = s_r.cmp[ci];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; stop mode simply freezes it with the clock
  always_ff @(posedge pclk or negedge presetn) begin // see (RULE21)
    if (!presetn) begin
      s_r <= '0;
      s_r.reload <= RELOAD_RST;
      s_r.cnt <= COUNT_RST;
      s_r.cmp <= {NCH{CMP_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign ch_out = s_r.out;
  assign irq = s_r.irq;
  assign dma_req = s_r.dma;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wrap_modulo_a: assert property (tick && s_r.cmode == MODE_MODULO && // see (RULE1)
    s_r.cnt == s_r.reload && !wr_cnt |=> s_r.cnt == 16'h0000 && s_r.cnt_flag)
    else $error("modulo wrap missed");
  mod_up_a: assert property (tick && s_r.cmode == MODE_MODULO && // see (RULE1)
    s_r.cnt < s_r.reload && !wr_cnt |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("modulo increment wrong");
  over_reload_a: assert property (tick && s_r.cmode == MODE_MODULO && !wr && // see (RULE2)
    s_r.cnt > s_r.reload |=> s_r.cnt == 16'h0000 && s_r.cnt_flag == $past(s_r.cnt_flag))
    else $error("restart from zero missed");
  down_step_a: assert property (tick && s_r.cmode == MODE_UPDOWN && // see (RULE3)
    s_r.cnt_down && s_r.cnt > 16'h0001 && !wr_cnt |=> s_r.cnt == $past(s_r.cnt) - 16'h0001)
    else $error("down count wrong");
  cycle_end_a: assert property (tick && s_r.cmode == MODE_UPDOWN && // see (RULE4)
    s_r.cnt_down && s_r.cnt == 16'h0001 && !wr_cnt |=> !s_r.cnt_down && s_r.cnt_flag)
    else $error("up/down cycle end missed");
  oneshot_pulse_a: assert property (ev[1] && s_r.ch_mode[1] == CH_ONESHOT && // see (RULE9)
    !wr |=> !s_r.ch_en[1] && ch_out[1] != s_r.ch_pol[1] ##1 ch_out[1] == s_r.ch_pol[1])
    else $error("one-shot pulse wrong");
  cont_stay_a: assert property (ev[0] && s_r.ch_mode[0] == CH_CONT && !wr // see (RULE10)
    |=> s_r.ch_en[0] && s_r.ev_flag[0] && ch_out[0] != s_r.ch_pol[0])
    else $error("continuous match wrong");
  capture_copy_a: assert property (ev[2] && s_r.ch_mode[2] == CH_CAPT && !wr // see (RULE15)
    |=> s_r.cmp[2] == $past(s_r.cnt) && s_r.ev_flag[2])
    else $error("capture value wrong");
  irq_merge_a: assert property (s_r.ev_flag[1] && s_r.ch_ie[1] && !wr // see (RULE18)
    |=> irq)
    else $error("channel interrupt lost");
  dma_drop_a: assert property (!s_r.ch_en[0] |-> !dma_req[0]) // see (RULE19)
    else $error("DMA request with channel off");
  deferred_cmp_a: assert property (wr && paddr[7:4] == CMP_REGION && ci == 2'd3 && // see (RULE6)
    s_r.tmr_en && !s_r.ch_upd[3] && !eoc && s_r.ch_mode[3] != CH_CAPT
    |=> s_r.cmp[3] == $past(s_r.cmp[3]) && s_r.buf_pend[3])
    else $error("compare write not deferred");

  pwm_wrap_a: assert property (tick && s_r.ch_en[3] && // see (RULE13)
    s_r.ch_mode[3] == CH_PWM && s_r.cmode == MODE_MODULO && s_r.cnt >= s_r.reload
    |=> ch_out[3] == $past(s_r.ch_pol[3]))
    else $error("PWM wrap restore missed");
  pwm_down_a: assert property (tick && ev[3] && s_r.ch_mode[3] == CH_PWM && // see (RULE14)
    s_r.cmode == MODE_UPDOWN && s_r.cnt_down |=> ch_out[3] == $past(s_r.ch_pol[3]))
    else $error("PWM down restore missed");
  hold_count_a: assert property (!s_r.tmr_en && !wr_cnt // see (RULE22)
    |=> s_r.cnt == $past(s_r.cnt))
    else $error("stopped counter moved");
  flag_hold_a: assert property (s_r.ev_flag[0] && !wr |=> s_r.ev_flag[0]) // see (RULE25)
    else $error("event flag lost");

  cov_wrap_c: cover property (eoc ##1 irq);
  cov_oneshot_c: cover property (ev[1] && s_r.ch_mode[1] == CH_ONESHOT);
  cov_pwm_c: cover property (ev[3] && s_r.ch_mode[3] == CH_PWM && s_r.cmode == MODE_UPDOWN);
  cov_dma_c: cover property (dma_req[0] ##1 dma_ack[0]);
  cov_capture_c: cover property (ev[2] && s_r.ch_mode[2] == CH_CAPT);
endmodule

// ==== testbench/far_side.sv ====
/*
  Far-side model: channel input pins and a DMA controller.
  Assumes pclk-synchronous pins and a DMA that acknowledges after ack_wait cycles.
*/
`timescale 1ns/1ps
module far_side import multichannel_counter_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic [NCH-1:0] pin_lv,
  input wire logic [3:0] ack_wait,
  // Block side
  input wire logic [NCH-1:0] dma_req,
  output logic [NCH-1:0] ch_in,
  output logic [NCH-1:0] dma_ack
);
  typedef struct packed {
    logic [NCH-1:0] pin;
    logic [NCH-1:0] ack;
    logic [3:0] cnt;
  } far_t;
  far_t st_r, st_nxt;
  //////////////////////////////////////////////////////////////////////
  // Pins follow bench levels; each request acked once after a wait
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin = pin_lv;
    st_nxt.ack = '0;
    if (dma_req != '0 && st_r.ack == '0) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      if (st_r.cnt == ack_wait) begin
        st_nxt.ack = dma_req;
        st_nxt.cnt = 4'h0;
      end
    end else begin
      st_nxt.cnt = 4'h0;
    end
  end
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign ch_in = st_r.pin;
  assign dma_ack = st_r.ack;
endmodule

// ==== testbench/multi_channel_capture_compare_timer_tb.sv ====
/*
  Self-checking bench for the multi-channel timer over APB.
  Assumes the far_side model for pins and DMA, and a wait-free APB slave.
*/
`timescale 1ns/1ps
module multi_channel_capture_compare_timer_tb import multichannel_counter_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, irq, err;
  logic [NCH-1:0] ch_in, ch_out, dma_req, dma_ack, pin_lv = '0;
  logic [3:0] ack_wait = 4'h0;
  int fail_count = 0, samples_checked = 0, n;
  //////////////////////////////////////////////////////////////////////
  // Clock, block and far side
  always #12.5 pclk = ~pclk;
  multichannel_counter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out), .irq(irq), .dma_req(dma_req),
    .dma_ack(dma_ack));
  far_side far (.pclk(pclk), .presetn(presetn), .pin_lv(pin_lv), .ack_wait(ack_wait),
    .dma_req(dma_req), .ch_in(ch_in), .dma_ack(dma_ack));
  //////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Channel control word with irq enable always set, enable as given
  function automatic logic [31:0] chc(logic en, logic [1:0] m, logic pol, logic upd);
    return {26'h0, upd, 1'b1, pol, m, en};
  endfunction
  // Wait until a channel output shows a level; n counts edges
  task wait_out(input int c, input logic lv);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ch_out[c] !== lv && n < 200);
  endtask
  // Edges between two rising pulses of channel c
  task period(input int c, output int p);
    wait_out(c, 1'b1);
    wait_out(c, 1'b0);
    p = n;
    wait_out(c, 1'b1);
    p = p + n;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Reset values and unmapped access
  task t_regs;
    apb(0, RELOAD_OFF, 0); chk(q, {16'h0, RELOAD_RST});
    apb(0, COUNT_OFF, 0); chk(q, {16'h0, COUNT_RST});
    apb(0, 8'h40, 0); chk({31'h0, err}, 1);
  endtask
  // Modulo and up/down periods seen on a continuous compare channel
  task t_period;
    int p;
    apb(1, RELOAD_OFF, 3);
    apb(1, {CMP_REGION, 4'h0}, 1);
    apb(1, {CHCTL_REGION, 4'h0}, chc(1, CH_CONT, 0, 1));
    apb(1, CTRL_OFF, 32'h9);
    period(0, p); period(0, p); chk(p, 4);
    chk(irq, 1);
    wait_out(0, 1'b1);
    n = 0;
    while (dma_req[0] !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(dma_req[0], 1);
    apb(1, {CMP_REGION, 4'h0}, 3);
    apb(1, CTRL_OFF, {28'h0, 1'b1, MODE_UPDOWN, 1'b1});
    period(0, p); period(0, p); chk(p, 6);
    apb(0, STATUS_OFF, 0); chk(q & 32'h11, 32'h11);
  endtask
  // One-shot pulse against high idle level, then self-disable
  task t_oneshot;
    apb(1, {CMP_REGION, 4'h4}, 2);
    apb(1, {CHCTL_REGION, 4'h4}, chc(0, CH_ONESHOT, 1, 1));
    repeat (2) @(posedge pclk);
    chk(ch_out[1], 1);
    apb(1, {CHCTL_REGION, 4'h4}, chc(1, CH_ONESHOT, 1, 1));
    wait_out(1, 1'b0);
    @(posedge pclk); chk(ch_out[1], 1);
    chk(dma_req[1], 0);
    apb(0, {CHCTL_REGION, 4'h4}, 0); chk(q[CH_EN_BIT], 0);
  endtask
  // Rising edge capture at a known count, falling edge ignored
  task t_capture;
    apb(1, {CHCTL_REGION, 4'h0}, 0);
    apb(1, CTRL_OFF, {28'h0, 1'b0, MODE_MODULO, 1'b1});
    apb(1, STATUS_OFF, 32'h1f);
    @(posedge pclk); chk(irq, 0);
    apb(1, {CHCTL_REGION, 4'h8}, chc(1, CH_CAPT, 1, 0));
    apb(1, COUNT_OFF, 1);
    pin_lv[2] <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(dma_req[2], 0);
    apb(0, STATUS_OFF, 0); chk(q & 32'hf, 32'h4);
    apb(0, {CMP_REGION, 4'h8}, 0); chk(q, 32'h2);
    apb(1, STATUS_OFF, 32'h1f);
    pin_lv[2] <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(0, STATUS_OFF, 0); chk(q & 32'hf, 32'h0);
  endtask
  // PWM levels in modulo, then in up/down counting
  task t_pwm;
    int p;
    apb(1, {CMP_REGION, 4'hc}, 1);
    repeat (4) @(posedge pclk);
    apb(1, {CHCTL_REGION, 4'hc}, chc(1, CH_PWM, 0, 0));
    wait_out(3, 1'b1);
    wait_out(3, 1'b0); chk(n, 2);
    period(3, p); chk(p, 4);
    apb(1, CTRL_OFF, {28'h0, 1'b0, MODE_UPDOWN, 1'b1});
    wait_out(3, 1'b0);
    wait_out(3, 1'b1);
    wait_out(3, 1'b0); chk(n, 4);
  endtask
  // Disabled counter holds, registers still writable
  task t_disable;
    logic [31:0] c0;
    apb(1, CTRL_OFF, 0);
    apb(0, COUNT_OFF, 0);
    c0 = q;
    apb(0, COUNT_OFF, 0); chk(q, c0);
    apb(1, RELOAD_OFF, 32'h5a);
    apb(0, RELOAD_OFF, 0); chk(q, 32'h5a);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_period;
    ack_wait <= 4'h3;
    t_oneshot;
    t_capture;
    t_pwm;
    t_disable;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test;
  end
endmodule
